// File: verilog/fsw_map.svh
`ifndef FSW_MAP_SVH
`define FSW_MAP_SVH

// report framing
`define FSW_RPT_LAST_IDX 6'h3F
`define FSW_CMD_WRITE_FLASH 8'hB1
`define FSW_SUB_CHIP 8'h00
`define FSW_SUB_PINS 8'h01
`define FSW_SUB_STR_LAST 8'h04
`define FSW_CHIP_LAST_IDX 5'h13
`define FSW_PINS_LAST_IDX 5'h04
`define FSW_FIRST_DATA_IDX 5'h02
`define FSW_PWD_FIRST_IDX 5'h0C

// chip byte 5 layout
`define FSW_B5_KEEP_MASK 8'h7C
`define FSW_B5_NEG_BIT 6
`define FSW_B5_POS_BIT 5
`define FSW_B5_VREF_HI 4
`define FSW_B5_VREF_LO 3
`define FSW_B5_INTREF_BIT 2

// pin settings byte layout and designation codes
`define FSW_PIN_LVL_BIT 4
`define FSW_PIN_DIR_BIT 3
`define FSW_DES_GPIO 3'h0
`define FSW_DES_ALT1 3'h1
`define FSW_DES_ALT2 3'h2
`define FSW_DES_ALT3 3'h3
`define FSW_DES_ALT4 3'h4
`define FSW_PIN0_DES_MAX 3'h2
`define FSW_PIN1_DES_MAX 3'h4
`define FSW_PIN2_DES_MAX 3'h3
`define FSW_PIN_RST 8'h08

// response status codes
`define FSW_RSP_OK 8'h00
`define FSW_RSP_UNSUPPORTED 8'h01

// register offsets (byte addresses) and bits
`define FSW_REG_CTRL 8'h00
`define FSW_REG_STATUS 8'h04
`define FSW_REG_CHIP 8'h08
`define FSW_REG_USB_ID 8'h0C
`define FSW_REG_PIN_STORED 8'h10
`define FSW_REG_PIN_ACTIVE 8'h14
`define FSW_REG_PIN_LEVEL 8'h18
`define FSW_REG_LAST_RSP 8'h1C
`define FSW_CTRL_APPLY_BIT 0
`define FSW_STATUS_INT_BIT 0
`define FSW_AXI_OKAY 2'h0
`define FSW_AXI_SLVERR 2'h2

`endif

// File: verilog/fsw_pkg.sv
package fsw_pkg;

  typedef enum logic [1:0] {
    FSW_ST_RECV,
    FSW_ST_DECIDE,
    FSW_ST_WALK,
    FSW_ST_RESP
  } fsw_state_e;

  typedef struct packed {
    fsw_state_e st;
    logic [5:0] idx;
    logic [7:0] cmd;
    logic [7:0] sub;
    logic [4:0] rd_idx;
    logic [4:0] wb_idx;
    logic wb_vld;
    logic [7:0] chip_b5;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [7:0] pwr_attr;
    logic [7:0] cur_half;
    logic [63:0] pwd;
    logic [2:0][7:0] pin_st;
    logic [2:0][7:0] pin_act;
    logic apply_pend;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_prev;
    logic int_flag;
    logic [2:0] pin_out;
    logic [2:0] pin_oe_n;
    logic rsp_vld;
    logic [7:0] rsp_cmd;
    logic [7:0] rsp_stat;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fsw_state_s;

endpackage

// File: verilog/fsw_report_ram.sv
`timescale 1ns/1ps
module fsw_report_ram (
  input wire logic i_clock,
  input wire logic i_we,
  input wire logic [5:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [5:0] i_raddr,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_q [64];
  logic [7:0] rdata_q;

  // no reset on the array: it only ever holds the report being decoded
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    rdata_q <= mem_q[i_raddr];
  end

  assign o_rdata = rdata_q;

endmodule

// File: verilog/fsw_top.sv
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fsw_map.svh"
// Function
// RL1 - report 0xB1 with sub-code 0x00 stores the chip settings bytes.
// RL2 - undefined sub-code answers with unsupported-command status at response byte 1.
// RL3 - byte 5 bit 6 enables flag on falling edge of interrupt input.
// RL4 - byte 5 bit 5 enables flag on rising edge of interrupt input.
// RL5 - byte 5 bits 4-3 select converter reference level, 00 turns it off.
// RL6 - byte 5 bit 2 picks internal reference module (1) or supply (0).
// RL7 - bytes 6 low and 7 high form the stored USB vendor identifier.
// RL8 - bytes 8 low and 9 high form the stored USB product identifier.
// RL9 - byte 10 becomes the configuration power attributes value.
// RL10 - requested current equals twice byte 11, in milliamperes.
// RL11 - bytes 12 to 19 are stored as the eight-byte password.
// RL12 - report 0xB1 with sub-code 0x01 stores the pin settings bytes.
// RL13 - general output pin drives bit 4 level at power-up or reset; here a reset restores 0x08, a GPIO input.
// RL14 - bit 3 sets direction, 1 input, only for general I/O pins.
// RL15 - pin 0 codes: GPIO, receive activity, suspend; higher codes ignored.
// RL16 - pin 1 codes: GPIO, clock, analog in, transmit activity, interrupt.
// RL17 - pin 2 codes: GPIO, clock, analog in 2, analog out; higher ignored.
// RL18 - don't-care bits and bytes 20 to 63 are accepted and ignored.
// RL19 - new pin settings reach the pins only at next reset or apply; here a reset restores the stored settings to 0x08 instead.
module fsw_top
  import fsw_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_rpt_valid,
  input wire logic i_rpt_first,
  input wire logic [7:0] i_rpt_data,
  output logic o_rpt_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_cmd,
  output logic [7:0] o_rsp_status,
  output logic o_int_neg_en,
  output logic o_int_pos_en,
  output logic [1:0] o_adc_vref_level,
  output logic o_adc_vref_internal,
  output logic [15:0] o_usb_vid,
  output logic [15:0] o_usb_pid,
  output logic [7:0] o_usb_power_attr,
  output logic [8:0] o_usb_current_ma,
  output logic o_int_detect_flag,
  input wire logic [2:0] i_pin_in,
  output logic [2:0] o_pin_out,
  output logic [2:0] o_pin_oe_n,
  input wire logic i_uart_rx_activity,
  input wire logic i_uart_tx_activity,
  input wire logic i_suspend,
  input wire logic i_clock_out_src,
  output logic o_analog_input_1_en,
  output logic o_analog_input_2_en,
  output logic o_analog_output_1_en,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic [7:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready
);

  logic [1:0] rst_sync_q;
  logic rst_n;
  fsw_state_s s_q;
  fsw_state_s s_d;
  logic mem_we;
  logic [5:0] mem_waddr;
  logic [5:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [2:0] pin_out_nx;
  logic [2:0] pin_oe_n_nx;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  fsw_report_ram u_ram (
    .i_clock(i_clock),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(i_rpt_data),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // drive of one pin from its active designation byte
  function automatic logic [1:0] pin_drive(input int pin, input logic [7:0] cfg);
    logic [1:0] r;
    r = {cfg[`FSW_PIN_LVL_BIT], cfg[`FSW_PIN_DIR_BIT]}; // see RL13 see RL14
    unique case (cfg[2:0])
      `FSW_DES_GPIO: r = {cfg[`FSW_PIN_LVL_BIT], cfg[`FSW_PIN_DIR_BIT]};
      `FSW_DES_ALT1: begin
        if (pin == 0) begin
          r = {i_uart_rx_activity, 1'b0}; // see RL15
        end else begin
          r = {i_clock_out_src, 1'b0}; // see RL16 see RL17
        end
      end
      `FSW_DES_ALT2: begin
        if (pin == 0) begin
          r = {i_suspend, 1'b0}; // see RL15
        end else begin
          r = 2'h1;
        end
      end
      `FSW_DES_ALT3: begin
        if (pin == 1) begin
          r = {i_uart_tx_activity, 1'b0}; // see RL16
        end else begin
          r = 2'h1;
        end
      end
      default: r = 2'h1;
    endcase
    return r;
  endfunction

  for (genvar g = 0; g < 3; g++) begin : g_pin
    logic [1:0] drv;
    assign drv = pin_drive(g, s_q.pin_act[g]);
    assign pin_out_nx[g] = drv[1];
    assign pin_oe_n_nx[g] = drv[0];
  end

  logic [4:0] walk_last;
  logic rpt_take;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic wr_ctrl_apply;
  logic wr_int_clear;
  logic int_rise;
  logic int_fall;
  logic int_event;
  logic [2:0] des;
  logic [5:0] pwd_sh;
  logic [4:0] pwd_off;

  assign walk_last = (s_q.sub == `FSW_SUB_CHIP) ? `FSW_CHIP_LAST_IDX : `FSW_PINS_LAST_IDX;
  assign rpt_take = i_rpt_valid && (s_q.st == FSW_ST_RECV);
  assign mem_we = rpt_take;
  assign mem_waddr = i_rpt_first ? 6'h00 : s_q.idx;
  assign mem_raddr = {1'b0, s_q.rd_idx};
  assign aw_take = i_axi_awvalid && !s_q.aw_have;
  assign w_take = i_axi_wvalid && !s_q.w_have;
  assign ar_take = i_axi_arvalid && !s_q.rvalid;
  assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign wr_ctrl_apply = wr_fire && (s_q.awaddr[7:2] == `FSW_REG_CTRL >> 2)
                         && s_q.wstrb[0] && s_q.wdata[`FSW_CTRL_APPLY_BIT];
  assign wr_int_clear = wr_fire && (s_q.awaddr[7:2] == `FSW_REG_STATUS >> 2)
                        && s_q.wstrb[0] && s_q.wdata[`FSW_STATUS_INT_BIT];
  // edge detection only while pin 1 serves as the interrupt input
  assign int_rise = s_q.pin_s2[1] && !s_q.pin_prev[1];
  assign int_fall = !s_q.pin_s2[1] && s_q.pin_prev[1];
  assign int_event = (s_q.pin_act[1][2:0] == `FSW_DES_ALT4)
                     && ((s_q.chip_b5[`FSW_B5_NEG_BIT] && int_fall) // see RL3
                     || (s_q.chip_b5[`FSW_B5_POS_BIT] && int_rise)); // see RL4
  assign pwd_off = s_q.wb_idx - `FSW_PWD_FIRST_IDX;
  assign pwd_sh = {pwd_off[2:0], 3'h0};

  always_comb begin
    s_d = s_q;
    s_d.rsp_vld = 1'b0;
    des = mem_rdata[2:0];
    // report reception and decode
    unique case (s_q.st)
      FSW_ST_RECV: begin
        if (rpt_take) begin
          s_d.idx = mem_waddr + 6'h01;
          if (mem_waddr == 6'h00) begin
            s_d.cmd = i_rpt_data;
          end
          if (mem_waddr == 6'h01) begin
            s_d.sub = i_rpt_data;
          end
          // bytes beyond the decoded range land in the buffer and are never read
          if (mem_waddr == `FSW_RPT_LAST_IDX) begin // see RL18
            s_d.st = FSW_ST_DECIDE;
            s_d.idx = 6'h00;
          end
        end
      end
      FSW_ST_DECIDE: begin
        s_d.rd_idx = `FSW_FIRST_DATA_IDX;
        s_d.wb_vld = 1'b0;
        s_d.rsp_cmd = s_q.cmd;
        s_d.rsp_stat = `FSW_RSP_OK;
        if (s_q.cmd != `FSW_CMD_WRITE_FLASH) begin
          s_d.st = FSW_ST_RECV;
        end else if (s_q.sub == `FSW_SUB_CHIP || s_q.sub == `FSW_SUB_PINS) begin
          s_d.st = FSW_ST_WALK; // see RL1 see RL12
        end else if (s_q.sub <= `FSW_SUB_STR_LAST) begin
          s_d.st = FSW_ST_RESP;
        end else begin
          s_d.rsp_stat = `FSW_RSP_UNSUPPORTED; // see RL2
          s_d.st = FSW_ST_RESP;
        end
      end
      FSW_ST_WALK: begin
        s_d.wb_vld = (s_q.rd_idx <= walk_last);
        s_d.wb_idx = s_q.rd_idx;
        if (s_q.rd_idx <= walk_last) begin
          s_d.rd_idx = s_q.rd_idx + 5'h01;
        end
        if (s_q.wb_vld && s_q.sub == `FSW_SUB_CHIP) begin
          unique case (s_q.wb_idx)
            5'h05: s_d.chip_b5 = mem_rdata & `FSW_B5_KEEP_MASK; // see RL18
            5'h06: s_d.vid[7:0] = mem_rdata; // see RL7
            5'h07: s_d.vid[15:8] = mem_rdata; // see RL7
            5'h08: s_d.pid[7:0] = mem_rdata; // see RL8
            5'h09: s_d.pid[15:8] = mem_rdata; // see RL8
            5'h0A: s_d.pwr_attr = mem_rdata; // see RL9
            5'h0B: s_d.cur_half = mem_rdata; // see RL10
            default: begin
              if (s_q.wb_idx >= `FSW_PWD_FIRST_IDX) begin
                s_d.pwd = (s_q.pwd & ~(64'hFF << pwd_sh))
                          | (64'(mem_rdata) << pwd_sh); // see RL11
              end
            end
          endcase
        end
        if (s_q.wb_vld && s_q.sub == `FSW_SUB_PINS) begin
          for (int p = 0; p < 3; p++) begin
            if (s_q.wb_idx == 5'(p + 2)) begin
              s_d.pin_st[p][7:3] = {3'h0, mem_rdata[4:3]}; // see RL13 see RL14
              // an out-of-range designation leaves the stored one untouched
              if ((p == 0 && des <= `FSW_PIN0_DES_MAX)
                  || (p == 1 && des <= `FSW_PIN1_DES_MAX)
                  || (p == 2 && des <= `FSW_PIN2_DES_MAX)) begin
                s_d.pin_st[p][2:0] = des; // see RL15 see RL16 see RL17
              end
            end
          end
        end
        if (s_q.wb_vld && s_q.wb_idx == walk_last) begin
          s_d.st = FSW_ST_RESP;
        end
      end
      FSW_ST_RESP: begin
        s_d.rsp_vld = 1'b1;
        s_d.st = FSW_ST_RECV;
      end
    endcase
    // stored pin settings reach the pins only on reset or an apply request
    if (s_q.apply_pend) begin
      s_d.pin_act = s_q.pin_st; // see RL19
    end
    s_d.apply_pend = wr_ctrl_apply;
    s_d.pin_s1 = i_pin_in;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_prev = s_q.pin_s2;
    s_d.pin_out = pin_out_nx;
    s_d.pin_oe_n = pin_oe_n_nx;
    // a new edge wins over a clear in the same cycle
    if (wr_int_clear) begin
      s_d.int_flag = 1'b0;
    end
    if (int_event) begin
      s_d.int_flag = 1'b1; // see RL3 see RL4
    end
    // register bus write side
    if (aw_take) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = i_axi_awaddr;
    end
    if (w_take) begin
      s_d.w_have = 1'b1;
      s_d.wdata = i_axi_wdata;
      s_d.wstrb = i_axi_wstrb;
    end
    if (wr_fire) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = (s_q.awaddr[7:2] == `FSW_REG_CTRL >> 2
                   || s_q.awaddr[7:2] == `FSW_REG_STATUS >> 2) ? `FSW_AXI_OKAY
                                                              : `FSW_AXI_SLVERR;
    end
    if (s_q.bvalid && i_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
    end
    // register bus read side
    if (s_q.rvalid && i_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `FSW_AXI_OKAY;
      s_d.rdata = 32'h0;
      unique case ({i_axi_araddr[7:2], 2'h0})
        `FSW_REG_CTRL: s_d.rdata = {31'h0, s_q.apply_pend};
        `FSW_REG_STATUS: s_d.rdata = {29'h0, s_q.st != FSW_ST_RECV,
                                      s_q.pwd != 64'h0, s_q.int_flag};
        `FSW_REG_CHIP: s_d.rdata = {8'h0, s_q.cur_half, s_q.pwr_attr, s_q.chip_b5};
        `FSW_REG_USB_ID: s_d.rdata = {s_q.pid, s_q.vid};
        `FSW_REG_PIN_STORED: s_d.rdata = {8'h0, s_q.pin_st};
        `FSW_REG_PIN_ACTIVE: s_d.rdata = {8'h0, s_q.pin_act};
        `FSW_REG_PIN_LEVEL: s_d.rdata = {29'h0, s_q.pin_s2};
        `FSW_REG_LAST_RSP: s_d.rdata = {16'h0, s_q.rsp_stat, s_q.rsp_cmd};
        default: s_d.rresp = `FSW_AXI_SLVERR;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= FSW_ST_RECV;
      s_q.pin_st <= {3{`FSW_PIN_RST}};
      s_q.pin_act <= {3{`FSW_PIN_RST}};
      s_q.pin_oe_n <= 3'h7;
      // first cycle after reset loads stored pin settings onto the pins
      s_q.apply_pend <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rpt_ready = (s_q.st == FSW_ST_RECV);
  assign o_rsp_valid = s_q.rsp_vld;
  assign o_rsp_cmd = s_q.rsp_cmd;
  assign o_rsp_status = s_q.rsp_stat;
  assign o_int_neg_en = s_q.chip_b5[`FSW_B5_NEG_BIT]; // see RL3
  assign o_int_pos_en = s_q.chip_b5[`FSW_B5_POS_BIT]; // see RL4
  assign o_adc_vref_level = s_q.chip_b5[`FSW_B5_VREF_HI:`FSW_B5_VREF_LO]; // see RL5
  assign o_adc_vref_internal = s_q.chip_b5[`FSW_B5_INTREF_BIT]; // see RL6
  assign o_usb_vid = s_q.vid;
  assign o_usb_pid = s_q.pid;
  assign o_usb_power_attr = s_q.pwr_attr;
  assign o_usb_current_ma = {s_q.cur_half, 1'b0}; // see RL10
  assign o_int_detect_flag = s_q.int_flag;
  assign o_pin_out = s_q.pin_out;
  assign o_pin_oe_n = s_q.pin_oe_n;
  assign o_analog_input_1_en = (s_q.pin_act[1][2:0] == `FSW_DES_ALT2); // see RL16
  assign o_analog_input_2_en = (s_q.pin_act[2][2:0] == `FSW_DES_ALT2); // see RL17
  assign o_analog_output_1_en = (s_q.pin_act[2][2:0] == `FSW_DES_ALT3); // see RL17
  assign o_axi_awready = !s_q.aw_have;
  assign o_axi_wready = !s_q.w_have;
  assign o_axi_bvalid = s_q.bvalid;
  assign o_axi_bresp = s_q.bresp;
  assign o_axi_arready = !s_q.rvalid;
  assign o_axi_rvalid = s_q.rvalid;
  assign o_axi_rdata = s_q.rdata;
  assign o_axi_rresp = s_q.rresp;

endmodule

// File: testbench/fsw_props.sv
`timescale 1ns/1ps
module fsw_props (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_rpt_valid,
  input wire logic i_rpt_first,
  input wire logic [7:0] i_rpt_data,
  input wire logic o_rpt_ready,
  input wire logic o_rsp_valid,
  input wire logic [7:0] o_rsp_cmd,
  input wire logic [7:0] o_rsp_status,
  input wire logic o_int_neg_en,
  input wire logic o_int_pos_en,
  input wire logic [1:0] o_adc_vref_level,
  input wire logic o_adc_vref_internal,
  input wire logic [15:0] o_usb_vid,
  input wire logic [15:0] o_usb_pid,
  input wire logic [7:0] o_usb_power_attr,
  input wire logic [8:0] o_usb_current_ma,
  input wire logic [2:0] o_pin_oe_n,
  input wire logic i_axi_awvalid
);
  logic [5:0] idx_q;
  logic [5:0] at;
  logic take;
  logic chip;
  logic [7:0] bt_q [12];
  assign take = i_rpt_valid && o_rpt_ready;
  assign at = i_rpt_first ? 6'h00 : idx_q;
  assign chip = o_rsp_valid && bt_q[1] == 8'h00;
  // only bytes 0 to 11 are kept, no property here checks any field past byte 11
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      idx_q <= 6'h00;
    end else if (take) begin
      idx_q <= at + 6'h01;
      if (at < 6'h0C) begin
        bt_q[at[3:0]] <= i_rpt_data;
      end
    end
  end
  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  AST_RSP_AFTER_LAST: assert property (
    take && at == 6'h3F && bt_q[0] == 8'hB1 |-> ##[1:40] o_rsp_valid)
    else $error("no response to a write report");
  AST_OTHER_SILENT: assert property (
    take && at == 6'h3F && bt_q[0] != 8'hB1 |=> !o_rsp_valid [*8])
    else $error("response to a foreign command");
  AST_READY_KEEP: assert property (
    take && at != 6'h3F |=> o_rpt_ready)
    else $error("report byte refused mid report");
  AST_STATUS: assert property (
    o_rsp_valid |-> o_rsp_cmd == bt_q[0] && o_rsp_status == {7'h00, bt_q[1] > 8'h04})
    else $error("bad response bytes");
  AST_IDS: assert property (
    chip |=> o_usb_vid == {bt_q[7], bt_q[6]} && o_usb_pid == {bt_q[9], bt_q[8]})
    else $error("bad usb identifiers");
  AST_POWER: assert property (
    chip |=> o_usb_power_attr == bt_q[10] && o_usb_current_ma == {bt_q[11], 1'h0})
    else $error("bad power fields");
  AST_REF: assert property (
    chip |=> {o_int_neg_en, o_int_pos_en, o_adc_vref_level, o_adc_vref_internal} == bt_q[5][6:2])
    else $error("bad byte five fields");
  AST_PIN_HOLD: assert property (
    o_rsp_valid && bt_q[1] == 8'h01 && !i_axi_awvalid |=> $stable(o_pin_oe_n) [*2])
    else $error("pins changed on a pin report");
endmodule
bind fsw_top fsw_props i_props (.*);

// File: testbench/fsw_host_model.sv
`timescale 1ns/1ps
module fsw_host_model (
  input wire logic i_clock,
  input wire logic i_ready,
  output logic o_valid = 1'h0,
  output logic o_first = 1'h0,
  output logic [7:0] o_data = 8'h00
);
  // a released byte lane shows the inverse of its last value, never a stale copy
  task automatic send(input logic [7:0] r [64], input int gap);
    for (int i = 0; i < 64; i++) begin
      o_valid <= 1'h1;
      o_first <= i == 0;
      o_data <= r[i];
      do @(posedge i_clock); while (i_ready !== 1'h1);
      if (gap > 0 || i == 63) begin
        o_valid <= 1'h0;
        o_first <= 1'h0;
        o_data <= ~r[i];
      end
      repeat (gap) @(posedge i_clock);
    end
  endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clock = 1'h0;
  logic i_nrst = 1'h0;
  logic i_rpt_valid, i_rpt_first, o_rpt_ready, o_rsp_valid, o_int_neg_en, o_int_pos_en;
  logic o_adc_vref_internal, o_int_detect_flag, o_analog_input_1_en, o_analog_input_2_en;
  logic o_analog_output_1_en, o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready;
  logic o_axi_rvalid, i_axi_awvalid = 1'h0, i_axi_wvalid = 1'h0, i_axi_bready = 1'h0;
  logic i_axi_arvalid = 1'h0, i_axi_rready = 1'h0, i_uart_rx_activity = 1'h0;
  logic i_uart_tx_activity = 1'h0, i_suspend = 1'h0, i_clock_out_src = 1'h0;
  logic [1:0] o_adc_vref_level, o_axi_bresp, o_axi_rresp, rs;
  logic [2:0] i_pin_in = 3'h0, o_pin_out, o_pin_oe_n, eoe = 3'h7, ana;
  logic [3:0] i_axi_wstrb = 4'hF;
  logic [7:0] i_rpt_data, o_rsp_cmd, o_rsp_status, o_usb_power_attr;
  logic [7:0] i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00;
  logic [7:0] r [64];
  logic [8:0] o_usb_current_ma;
  logic [15:0] o_usb_vid, o_usb_pid;
  logic [31:0] i_axi_wdata = 32'h0, o_axi_rdata, rd, seed = 32'h77515AD6;
  int fails = 0;
  int comparisons = 0;
  int des[3] = '{0, 0, 0};
  int exp_q[$];
  assign ana = {o_analog_input_1_en, o_analog_input_2_en, o_analog_output_1_en};
  always #2 i_clock = ~i_clock;
  fsw_top i_dut (.*);
  fsw_host_model i_host (.i_clock, .i_ready(o_rpt_ready), .o_valid(i_rpt_valid),
    .o_first(i_rpt_first), .o_data(i_rpt_data));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge i_clock) begin
    if (o_rsp_valid === 1'h1) begin
      chk("response", exp_q.size() ? exp_q.pop_front() : -1, {o_rsp_cmd, o_rsp_status});
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] b);
    @(posedge i_clock);
    i_axi_awaddr <= a;
    i_axi_wdata <= d;
    i_axi_awvalid <= 1'h1;
    i_axi_wvalid <= 1'h1;
    i_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge i_clock); while (o_axi_awready !== 1'h1);
        i_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge i_clock); while (o_axi_wready !== 1'h1);
        i_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge i_clock); while (o_axi_bvalid !== 1'h1);
    b = o_axi_bresp;
    i_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
    @(posedge i_clock);
    i_axi_araddr <= a;
    i_axi_arvalid <= 1'h1;
    i_axi_rready <= 1'h1;
    do @(posedge i_clock); while (o_axi_arready !== 1'h1);
    i_axi_arvalid <= 1'h0;
    do @(posedge i_clock); while (o_axi_rvalid !== 1'h1);
    d = o_axi_rdata;
    s = o_axi_rresp;
    i_axi_rready <= 1'h0;
  endtask
  task automatic fill(input logic [7:0] c, input logic [7:0] s);
    foreach (r[i]) r[i] = rnd();
    r[0] = c;
    r[1] = s;
  endtask
  task automatic rpt(input int gap);
    if (r[0] == 8'hB1) exp_q.push_back({r[0], 7'h00, r[1] > 8'h04});
    i_host.send(r, gap);
    for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge i_clock);
    chk("pending responses", 0, exp_q.size());
  endtask
  task automatic pins(input int c);
    logic [2:0] o;
    int d;
    for (int p = 0; p < 3; p++) begin
      if (c <= (p == 0 ? 2 : p == 1 ? 4 : 3)) des[p] = c;
      d = des[p];
      eoe[p] = d == 0 ? r[p + 2][3] : !(d == 1 || (p == 0 && d == 2) || (p == 1 && d == 3));
      o[p] = d == 0 ? r[p + 2][4] : d == 1 ? (p == 0 ? i_uart_rx_activity : i_clock_out_src)
        : p == 0 ? i_suspend : i_uart_tx_activity;
    end
    chk("pin drive", eoe, o_pin_oe_n);
    chk("pin level", o & ~eoe, o_pin_out & ~eoe);
    chk("analog", {des[1] == 2, des[2] == 2, des[2] == 3}, ana);
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_nrst <= 1'h1;
    repeat (3) @(posedge i_clock);
    // 0x20 is past the map, so it must answer with an error
    for (int i = 1; i < 9; i++) begin
      axr(8'(4 * i), rd, rs);
      chk("reset read", (i == 4 || i == 5) ? 32'h00080808 : 32'h0, rd);
      chk("read resp", (i == 8) ? 32'h2 : 32'h0, rs);
    end
    axw(8'h08, 32'hFFFFFFFF, rs);
    chk("write resp", 32'h2, rs);
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      fill(8'hB1, 8'h00);
      r[5] = {r[5][7], i[0], i[1], i[1:0], i[0], r[5][1:0]};
      if (i == 3) r[11] = 8'hFF;
      if (i == 2) for (int k = 12; k < 20; k++) r[k] = 8'h00;
      rpt(i % 2);
      chk("vid", {r[7], r[6]}, o_usb_vid);
      chk("pid", {r[9], r[8]}, o_usb_pid);
      chk("power attr", r[10], o_usb_power_attr);
      chk("current", 2 * r[11], o_usb_current_ma);
      chk("edge enables", {i[0], i[1]}, {o_int_neg_en, o_int_pos_en});
      chk("vref level", i[1:0], o_adc_vref_level);
      chk("vref source", i[0], o_adc_vref_internal);
      axr(8'h08, rd, rs);
      chk("chip reg", {r[11], r[10], r[5] & 8'h7C}, rd);
      axr(8'h04, rd, rs);
      chk("password set", i != 2, rd[1]);
      $display("test chip settings %0d done", i);
    end
    for (int s = 2; s < 7; s++) begin
      fill(8'hB1, s == 6 ? 8'hFF : 8'(s));
      rpt(0);
    end
    fill(8'h5A, 8'h00);
    rpt(0);
    repeat (30) @(posedge i_clock);
    $display("test sub-codes done");
    for (int c = 0; c < 8; c++) begin
      fill(8'hB1, 8'h01);
      for (int p = 0; p < 3; p++) r[p + 2] = {r[p + 2][7:3], 3'(c)};
      {i_uart_rx_activity, i_uart_tx_activity, i_suspend, i_clock_out_src, i_pin_in} <= 7'(rnd());
      rpt(c % 2);
      chk("pins held", eoe, o_pin_oe_n);
      axw(8'h00, 32'h1, rs);
      chk("apply resp", 0, rs);
      repeat (3) @(posedge i_clock);
      pins(c);
    end
    $display("test pins done");
    i_pin_in[1] <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      fill(8'hB1, 8'h00);
      r[5] = k ? 8'h40 : 8'h20;
      rpt(0);
      for (int e = 0; e < 2; e++) begin
        axw(8'h04, 32'h1, rs);
        i_pin_in[1] <= !e;
        repeat (10) @(posedge i_clock);
        chk("int flag", e == k, o_int_detect_flag);
        axr(8'h04, rd, rs);
        chk("int status", e == k, rd[0]);
      end
    end
    $display("test interrupt done");
    results();
  end
  initial begin
    repeat (40000) @(posedge i_clock);
    fails++;
    results();
  end
endmodule
